/* verilog/ppp_defs.vh */
/*
  Constants for the parallel programming port: command bytes, decoded
  operation classes, fuse byte layout and defaults, page geometry.
  Assumes inclusion by bare name from each design file.
*/
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH
// ----------------------------------------
// command bytes
// ----------------------------------------
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
// ----------------------------------------
// decoded operation classes
// ----------------------------------------
`define PPP_OP_NOP 4'h0
`define PPP_OP_ERASE 4'h1
`define PPP_OP_WFUSE 4'h2
`define PPP_OP_WLOCK 4'h3
`define PPP_OP_WFLASH 4'h4
`define PPP_OP_WEE 4'h5
`define PPP_OP_RSIG 4'h6
`define PPP_OP_RFUSE 4'h7
`define PPP_OP_RFLASH 4'h8
`define PPP_OP_REE 4'h9
// ----------------------------------------
// action select coding
// ----------------------------------------
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
// ----------------------------------------
// fuse layout and defaults (0 = programmed)
// ----------------------------------------
`define PPP_FUSE_LOW_RST 8'h62
`define PPP_FUSE_HIGH_RST 8'hdf
`define PPP_FUSE_EXT_RST 8'hff
`define PPP_LOCK_RST 8'hff
`define PPP_LOCK_KEEP 8'hfc
`define PPP_FL_DIV8 7
`define PPP_FL_CLOCK_OUT_FUSE 6
`define PPP_FL_SUT_HI 5
`define PPP_FL_SUT_LO 4
`define PPP_FL_CKSEL_HI 3
`define PPP_FL_CKSEL_LO 0
`define PPP_FH_EEKEEP 3
// ----------------------------------------
// page geometry
// ----------------------------------------
`define PPP_FL_WORD_MSB 5
`define PPP_FL_PAGE_LSB 6
`define PPP_EE_WORD_MSB 1
`define PPP_EE_PAGE_LSB 2
`define PPP_EE_PAGE_MSB 8
`define PPP_SIG_ADDR_W 2
`endif

/* verilog/ppp_sync.v */
/*
  Two-flop synchroniser for a bundle of pins.
  Assumes each bit is independent; multi-bit values are only used
  once settled (the programmer keeps them stable around strobes).
*/
`include "ppp_defs.vh"
module ppp_sync #(
  parameter W = 15
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

/* verilog/ppp_cmd_dec.v */
/*
  Command byte decoder: maps a command byte to an operation class.
  Assumes a combinational consumer on the same clock.
*/
`include "ppp_defs.vh"
module ppp_cmd_dec (
  input wire [7:0] cmd_i,
  output reg [3:0] op_o
);
  always @* begin
    case (cmd_i)
      `PPP_CMD_ERASE: op_o = `PPP_OP_ERASE;
      `PPP_CMD_WFUSE: op_o = `PPP_OP_WFUSE;
      `PPP_CMD_WLOCK: op_o = `PPP_OP_WLOCK;
      `PPP_CMD_WFLASH: op_o = `PPP_OP_WFLASH;
      `PPP_CMD_WEE: op_o = `PPP_OP_WEE;
      `PPP_CMD_RSIG: op_o = `PPP_OP_RSIG;
      `PPP_CMD_RFUSE: op_o = `PPP_OP_RFUSE;
      `PPP_CMD_RFLASH: op_o = `PPP_OP_RFLASH;
      `PPP_CMD_REE: op_o = `PPP_OP_REE;
      default: op_o = `PPP_OP_NOP;
    endcase
  end
endmodule

/* verilog/ppp_top.v */
/*
  Parallel programming port front end: pin sampling, command, address
  and data loading, fuse store with session latching, identification
  reads, page latch requests and ready/busy.
  Assumes a memory back end on core_clk_i that takes op_start_o,
  page_load_o and answers op_done_i, and presents read data on
  mem_rdata_i for mem_addr_o within one cycle. Pins are asynchronous.
*/
`include "ppp_defs.vh"
module ppp_top #(
  parameter PCMSB = 12,
  parameter [7:0] SIG_BYTE0 = 8'h5a,
  parameter [7:0] SIG_BYTE1 = 8'h01,
  parameter [7:0] SIG_BYTE2 = 8'h02,
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire prog_clock_pin_i,
  input wire action_select_hi_i,
  input wire action_select_lo_i,
  input wire page_latch_strobe_i,
  input wire write_n_i,
  input wire output_enable_n_i,
  input wire hv_entry_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output reg data_oe_o,
  output reg ready_not_busy_o,
  output reg prog_mode_o,
  output reg op_start_o,
  output reg [3:0] op_code_o,
  output reg erase_eeprom_o,
  input wire op_done_i,
  output reg [15:0] mem_addr_o,
  output reg [6:0] page_index_o,
  input wire [15:0] mem_rdata_i,
  output reg page_load_o,
  output reg [5:0] page_word_o,
  output reg [15:0] page_data_o,
  output reg [7:0] eff_fuse_low_o,
  output reg [7:0] eff_fuse_high_o,
  output reg [7:0] eff_fuse_ext_o,
  output reg [7:0] lock_bits_o,
  output reg eeprom_keep_o,
  output reg clock_div8_en_o,
  output reg clock_out_en_o,
  output reg [7:0] rc_trim_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function is_write;
    input [3:0] op;
    begin
      is_write = (op == `PPP_OP_ERASE) || (op == `PPP_OP_WFUSE) ||
                 (op == `PPP_OP_WLOCK) || (op == `PPP_OP_WFLASH) ||
                 (op == `PPP_OP_WEE);
    end
  endfunction

  function is_read;
    input [3:0] op;
    begin
      is_read = (op == `PPP_OP_RSIG) || (op == `PPP_OP_RFUSE) ||
                (op == `PPP_OP_RFLASH) || (op == `PPP_OP_REE);
    end
  endfunction

  function is_page_op;
    input [3:0] op;
    begin
      is_page_op = (op == `PPP_OP_WFLASH) || (op == `PPP_OP_WEE);
    end
  endfunction

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  wire [14:0] s;
  reg [14:0] s_d;

  ppp_sync #(
    .W(15)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({prog_clock_pin_i, action_select_hi_i, action_select_lo_i,
          page_latch_strobe_i, write_n_i, output_enable_n_i,
          hv_entry_i, data_i}),
    .q_o(s)
  );

  wire xclk = s[14];
  wire [1:0] act = s[13:12];
  wire byte_sel_second_high = s[13];
  wire byte_sel_low_high = s[11];
  wire wr_n = s[10];
  wire oe_n = s[9];
  wire hv = s[8];
  wire [7:0] din = s[7:0];

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_d <= 15'h0000;
    end else begin
      s_d <= s;
    end
  end

  wire xclk_rise = xclk & ~s_d[14];
  wire pl_fall = ~byte_sel_low_high & s_d[11];
  wire wr_fall = ~wr_n & s_d[10];
  wire hv_rise = hv & ~s_d[8];
  wire hv_fall = ~hv & s_d[8];
  // entry pins must all be low as the high voltage arrives
  wire entry_ok = ~byte_sel_low_high & ~act[1] & ~act[0] & ~wr_n;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  reg [7:0] cmd;
  wire [3:0] op;

  ppp_cmd_dec u_dec (
    .cmd_i(cmd),
    .op_o(op)
  );

  // ----------------------------------------
  // session, loads, writes
  // ----------------------------------------
  reg [7:0] fuse_low;
  reg [7:0] fuse_high;
  reg [7:0] fuse_ext;
  reg [15:0] wdata;
  reg wr_ctl;
  reg latch_pend;
  reg captured;
  wire enter = hv_rise & entry_ok & ~prog_mode_o;
  wire leave = hv_fall & prog_mode_o;
  wire capture = enter | leave | ~captured;
  wire accept = prog_mode_o & ready_not_busy_o;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_mode_o <= 1'b0;
      captured <= 1'b0;
      cmd <= `PPP_CMD_NOP;
      mem_addr_o <= 16'h0000;
      wdata <= 16'h0000;
      wr_ctl <= 1'b0;
      latch_pend <= 1'b0;
      ready_not_busy_o <= 1'b1;
      op_start_o <= 1'b0;
      op_code_o <= `PPP_OP_NOP;
      erase_eeprom_o <= 1'b0;
      page_load_o <= 1'b0;
      page_word_o <= 6'h00;
      page_data_o <= 16'h0000;
      fuse_low <= `PPP_FUSE_LOW_RST;
      fuse_high <= `PPP_FUSE_HIGH_RST;
      fuse_ext <= `PPP_FUSE_EXT_RST;
      lock_bits_o <= `PPP_LOCK_RST;
    end else begin
      op_start_o <= 1'b0;
      page_load_o <= 1'b0;
      captured <= 1'b1;
      if (enter) begin
        prog_mode_o <= 1'b1;
      end else if (leave) begin
        prog_mode_o <= 1'b0;
        wr_ctl <= 1'b0;
      end
      // busy until the back end reports completion
      if (!ready_not_busy_o && op_done_i) begin
        ready_not_busy_o <= 1'b1;
      end
      // loads on a rising prog clock; command and address persist
      if (prog_mode_o && xclk_rise) begin
        case (act)
          `PPP_ACT_ADDR: begin
            if (byte_sel_low_high) begin
              mem_addr_o[15:8] <= din;
            end else begin
              mem_addr_o[7:0] <= din;
            end
          end
          `PPP_ACT_DATA: begin
            if (byte_sel_low_high && op == `PPP_OP_WFLASH) begin
              wdata[15:8] <= din;
            end else begin
              wdata[7:0] <= din;
            end
            latch_pend <= (op == `PPP_OP_WEE) | byte_sel_low_high;
          end
          `PPP_ACT_CMD: begin
            if (ready_not_busy_o) begin
              cmd <= din;
              // nop or unknown byte ends any page sequence
              wr_ctl <= (din == `PPP_CMD_WFLASH) || (din == `PPP_CMD_WEE);
            end
          end
          default: begin
          end
        endcase
      end
      // page latch shares the byte select pin: latch on its fall
      // once the word is complete, so selecting the high byte is harmless
      if (prog_mode_o && pl_fall && latch_pend && wr_ctl && is_page_op(op)) begin
        page_load_o <= 1'b1;
        page_data_o <= wdata;
        // a data load in the same cycle keeps its own pending flag
        if (!(xclk_rise && act == `PPP_ACT_DATA)) begin
          latch_pend <= 1'b0;
        end
        if (op == `PPP_OP_WEE) begin
          page_word_o <= {4'h0, mem_addr_o[`PPP_EE_WORD_MSB:0]};
        end else begin
          page_word_o <= mem_addr_o[`PPP_FL_WORD_MSB:0];
        end
      end
      // write strobe starts the loaded operation
      if (accept && wr_fall && is_write(op)) begin
        op_start_o <= 1'b1;
        op_code_o <= op;
        ready_not_busy_o <= 1'b0;
        case (op)
          `PPP_OP_ERASE: begin
            lock_bits_o <= `PPP_LOCK_RST;
            erase_eeprom_o <= fuse_high[`PPP_FH_EEKEEP];
          end
          `PPP_OP_WFUSE: begin
            if (byte_sel_second_high) begin
              fuse_ext <= wdata[7:0];
            end else if (byte_sel_low_high) begin
              fuse_high <= wdata[7:0];
            end else begin
              fuse_low <= wdata[7:0];
            end
          end
          `PPP_OP_WLOCK: begin
            // lock bits only program here; erase or reset releases them
            lock_bits_o <= lock_bits_o & (`PPP_LOCK_KEEP | wdata[7:0]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // effective fuses
  // ----------------------------------------
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eff_fuse_low_o <= `PPP_FUSE_LOW_RST;
      eff_fuse_high_o <= `PPP_FUSE_HIGH_RST;
      eff_fuse_ext_o <= `PPP_FUSE_EXT_RST;
      clock_div8_en_o <= (`PPP_FUSE_LOW_RST >> `PPP_FL_DIV8) == 8'h00;
      clock_out_en_o <= 1'b0;
      eeprom_keep_o <= 1'b0;
      rc_trim_o <= CAL_BYTE;
    end else begin
      // keep fuse bypasses session latching
      eeprom_keep_o <= ~fuse_high[`PPP_FH_EEKEEP];
      if (capture) begin
        eff_fuse_low_o <= fuse_low;
        eff_fuse_high_o <= fuse_high;
        eff_fuse_ext_o <= fuse_ext;
        clock_div8_en_o <= ~fuse_low[`PPP_FL_DIV8];
        clock_out_en_o <= ~fuse_low[`PPP_FL_CLOCK_OUT_FUSE];
      end
    end
  end

  // ----------------------------------------
  // page index of the loaded address
  // ----------------------------------------
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_index_o <= 7'h00;
    end else if (op == `PPP_OP_WEE || op == `PPP_OP_REE) begin
      page_index_o <= mem_addr_o[`PPP_EE_PAGE_MSB:`PPP_EE_PAGE_LSB];
    end else begin
      page_index_o <= mem_addr_o[PCMSB:`PPP_FL_PAGE_LSB] & 7'h7f;
    end
  end

  // ----------------------------------------
  // read data and bus drive
  // ----------------------------------------
  reg [7:0] rd_byte;
  wire [1:0] sig_addr = mem_addr_o[`PPP_SIG_ADDR_W-1:0];

  always @* begin
    rd_byte = 8'h00;
    case (op)
      `PPP_OP_RSIG: begin
        // identification readable whatever the lock state
        if (byte_sel_low_high) begin
          rd_byte = (sig_addr == 2'h0) ? rc_trim_o : 8'h00;
        end else begin
          case (sig_addr)
            2'h0: rd_byte = SIG_BYTE0;
            2'h1: rd_byte = SIG_BYTE1;
            2'h2: rd_byte = SIG_BYTE2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      `PPP_OP_RFUSE: begin
        case ({byte_sel_second_high, byte_sel_low_high})
          2'h0: rd_byte = fuse_low;
          2'h1: rd_byte = lock_bits_o;
          2'h2: rd_byte = fuse_ext;
          default: rd_byte = fuse_high;
        endcase
      end
      `PPP_OP_RFLASH: rd_byte = byte_sel_low_high ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
      `PPP_OP_REE: rd_byte = mem_rdata_i[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_oe_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      data_oe_o <= prog_mode_o & ~oe_n & is_read(op);
      data_o <= rd_byte;
    end
  end
endmodule

/* verification/ppp_top_assertions.sv */
/*
  Port checker for ppp_top, bound into every instance.
  Assumes one clock domain and the async active-low reset.
*/
module ppp_top_chk #(
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input logic core_clk_i,
  input logic nrst_i,
  input logic write_n_i,
  input logic output_enable_n_i,
  input logic op_done_i,
  input logic data_oe_o,
  input logic ready_not_busy_o,
  input logic prog_mode_o,
  input logic op_start_o,
  input logic page_load_o,
  input logic [7:0] eff_fuse_low_o,
  input logic clock_div8_en_o,
  input logic clock_out_en_o,
  input logic [7:0] rc_trim_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----
  // assertions
  // ----
  a_oe_needs_strobe: assert property ($rose(data_oe_o) |-> prog_mode_o && !$past(output_enable_n_i))
    else $error("bus driven without enable");
  a_oe_release: assert property (output_enable_n_i [*6] |-> !data_oe_o)
    else $error("bus still driven");
  a_start_cause: assert property (op_start_o |-> prog_mode_o && !$past(write_n_i) && $past(ready_not_busy_o))
    else $error("start without write strobe");
  a_start_pulse: assert property (op_start_o |=> !op_start_o)
    else $error("start longer than one cycle");
  a_busy_after_start: assert property (op_start_o |-> ##[0:1] !ready_not_busy_o)
    else $error("ready not dropped");
  a_ready_return: assert property (op_done_i && !ready_not_busy_o |=> ready_not_busy_o)
    else $error("ready not restored");
  a_load_pulse: assert property (page_load_o |=> !page_load_o)
    else $error("page load too long");
  a_fuse_held: assert property (prog_mode_o && $past(prog_mode_o) |-> $stable(eff_fuse_low_o))
    else $error("fuse changed in session");
  a_trim_cal: assert property (rc_trim_o == CAL_BYTE)
    else $error("trim not calibration byte");
  a_fuse_decode: assert property (prog_mode_o [*3] |->
    clock_div8_en_o == !eff_fuse_low_o[7] && clock_out_en_o == !eff_fuse_low_o[6])
    else $error("fuse field decode wrong");
  c_start: cover property (op_start_o);
  c_load: cover property (page_load_o);
  c_read: cover property ($rose(data_oe_o));
  c_exit: cover property ($fell(prog_mode_o));
endmodule

bind ppp_top ppp_top_chk #(.CAL_BYTE(CAL_BYTE)) u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .write_n_i(write_n_i),
  .output_enable_n_i(output_enable_n_i), .op_done_i(op_done_i), .data_oe_o(data_oe_o),
  .ready_not_busy_o(ready_not_busy_o), .prog_mode_o(prog_mode_o), .op_start_o(op_start_o),
  .page_load_o(page_load_o), .eff_fuse_low_o(eff_fuse_low_o), .clock_div8_en_o(clock_div8_en_o),
  .clock_out_en_o(clock_out_en_o), .rc_trim_o(rc_trim_o)
);

/* verification/ppp_mem_model.sv */
/*
  Memory back end stand-in: read data from the address, done after dly_i.
  Assumes op_start_i is a one-cycle pulse and dly_i is at least 2.
*/
module ppp_mem_model #(
  parameter [15:0] MASK = 16'ha5c3
) (
  input logic core_clk_i,
  input logic nrst_i,
  input logic op_start_i,
  input logic [7:0] dly_i,
  input logic [15:0] mem_addr_i,
  output logic op_done_o,
  output logic [15:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // every address reads back a distinct, predictable word
  assign mem_rdata_o = mem_addr_i ^ MASK;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      op_done_o <= 1'b0;
    end else begin
      op_done_o <= (cnt == 1);
      if (op_start_i) begin
        cnt <= dly_i;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

/* verification/ppp_top_test.sv */
/*
  Self-checking bench for ppp_top acting as the parallel programmer.
  Assumes ppp_mem_model as back end and the bound port checker.
*/
module ppp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [15:0] MASK = 16'ha5c3;
  // identification and calibration values are arbitrary
  localparam [7:0] SIG0 = 8'h3c, SIG1 = 8'h11, SIG2 = 8'h22, CAL = 8'h6e;
  logic core_clk_i, nrst_i, prog_clock_pin_i, action_select_hi_i, action_select_lo_i;
  logic page_latch_strobe_i, write_n_i, output_enable_n_i, hv_entry_i, op_done_i;
  logic data_oe_o, ready_not_busy_o, prog_mode_o, op_start_o, erase_eeprom_o, page_load_o;
  logic eeprom_keep_o, clock_div8_en_o, clock_out_en_o, s, b;
  logic [7:0] data_i, data_o, eff_fuse_low_o, eff_fuse_high_o, eff_fuse_ext_o, lock_bits_o, rc_trim_o, dly;
  logic [3:0] op_code_o;
  logic [6:0] page_index_o;
  logic [5:0] page_word_o;
  logic [15:0] mem_addr_o, mem_rdata_i, page_data_o;
  int num_errors = 0, num_checks = 0, n;
  ppp_top #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .prog_clock_pin_i(prog_clock_pin_i),
    .action_select_hi_i(action_select_hi_i), .action_select_lo_i(action_select_lo_i),
    .page_latch_strobe_i(page_latch_strobe_i), .write_n_i(write_n_i),
    .output_enable_n_i(output_enable_n_i), .hv_entry_i(hv_entry_i), .data_i(data_i),
    .data_o(data_o), .data_oe_o(data_oe_o), .ready_not_busy_o(ready_not_busy_o),
    .prog_mode_o(prog_mode_o), .op_start_o(op_start_o), .op_code_o(op_code_o),
    .erase_eeprom_o(erase_eeprom_o), .op_done_i(op_done_i), .mem_addr_o(mem_addr_o),
    .page_index_o(page_index_o), .mem_rdata_i(mem_rdata_i), .page_load_o(page_load_o),
    .page_word_o(page_word_o), .page_data_o(page_data_o), .eff_fuse_low_o(eff_fuse_low_o),
    .eff_fuse_high_o(eff_fuse_high_o), .eff_fuse_ext_o(eff_fuse_ext_o), .lock_bits_o(lock_bits_o),
    .eeprom_keep_o(eeprom_keep_o), .clock_div8_en_o(clock_div8_en_o),
    .clock_out_en_o(clock_out_en_o), .rc_trim_o(rc_trim_o)
  );
  ppp_mem_model #(.MASK(MASK)) mem (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .op_start_i(op_start_o), .dly_i(dly),
    .mem_addr_i(mem_addr_o), .op_done_o(op_done_i), .mem_rdata_o(mem_rdata_i)
  );
  initial begin
    core_clk_i = 0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // ----
  // helpers
  // ----
  task tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #2;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one load on the link clock pin, 300 ns period, pins held around it
  task ld(input logic [1:0] act, input logic bs, input logic [7:0] d);
    {action_select_hi_i, action_select_lo_i} = act;
    page_latch_strobe_i = bs;
    data_i = d;
    tick(4);
    prog_clock_pin_i = 1;
    tick(4);
    prog_clock_pin_i = 0;
    tick(4);
  endtask
  // write strobe of 10 cycles (250 ns), then bounded wait for ready
  task wr(output logic seen, output logic busy);
    seen = 0;
    write_n_i = 0;
    for (n = 0; n < 10; n++) begin
      tick(1);
      if (op_start_o === 1'b1) seen = 1;
    end
    busy = ready_not_busy_o;
    write_n_i = 1;
    for (n = 0; n < 80 && ready_not_busy_o !== 1'b1; n++) tick(1);
    if (n == 80) begin
      num_errors++;
      $display("BAD %0t ready never returned", $time);
      results();
    end
    tick(4);
  endtask
  task rd(input logic bs, input logic [7:0] exp);
    page_latch_strobe_i = bs;
    output_enable_n_i = 0;
    tick(8);
    chk(data_oe_o, 1);
    chk(data_o, exp);
    output_enable_n_i = 1;
    tick(8);
    chk(data_oe_o, 0);
  endtask
  task enter;
    {page_latch_strobe_i, action_select_hi_i, action_select_lo_i, write_n_i} = 4'h0;
    tick(8);
    hv_entry_i = 1;
    tick(8);
    write_n_i = 1;
    tick(8);
    chk(prog_mode_o, 1);
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    chk(eff_fuse_low_o, 8'h62);
    chk({clock_div8_en_o, clock_out_en_o}, 2'h2);
    chk(rc_trim_o, CAL);
    chk({ready_not_busy_o, prog_mode_o}, 2'h2);
    ld(2'h0, 1'b0, 8'h77);
    chk(mem_addr_o, 16'h0000);
  endtask
  task t_wflash;
    ld(2'h2, 1'b0, 8'h10);
    ld(2'h0, 1'b0, 8'h05);
    ld(2'h1, 1'b0, 8'h11);
    ld(2'h1, 1'b1, 8'h22);
    page_latch_strobe_i = 0;
    for (n = 0; n < 10 && page_load_o !== 1'b1; n++) tick(1);
    chk(page_load_o, 1);
    chk({page_word_o, page_data_o}, {6'h05, 16'h2211});
    wr(s, b);
    chk({s, b, op_code_o}, {2'h2, 4'h4});
    ld(2'h2, 1'b0, 8'h00);
    wr(s, b);
    chk(s, 0);
  endtask
  task t_cmds;
    logic [7:0] c[4] = '{8'h80, 8'h40, 8'h20, 8'h11};
    logic [3:0] o[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
    for (int i = 0; i < 4; i++) begin
      ld(2'h2, 1'b0, c[i]);
      // data load puts the byte select 2 pin low again before the strobe
      ld(2'h1, 1'b0, 8'hff);
      if (i == 3) begin
        page_latch_strobe_i = 1;
        tick(4);
        page_latch_strobe_i = 0;
        for (n = 0; n < 10 && page_load_o !== 1'b1; n++) tick(1);
        chk({page_load_o, page_word_o, page_data_o[7:0]}, {1'b1, 6'h01, 8'hff});
      end
      wr(s, b);
      chk({s, b, op_code_o}, {2'h2, o[i]});
      if (i == 0) chk(erase_eeprom_o, 1);
    end
  endtask
  task t_fuse;
    ld(2'h2, 1'b0, 8'h40);
    chk(eff_fuse_low_o, 8'h62);
    ld(2'h1, 1'b0, 8'hd7);
    page_latch_strobe_i = 1;
    tick(4);
    wr(s, b);
    chk({eeprom_keep_o, eff_fuse_high_o}, {1'b1, 8'hdf});
    dly = 3;
    ld(2'h2, 1'b0, 8'h80);
    wr(s, b);
    chk({s, erase_eeprom_o}, 2'h2);
    ld(2'h2, 1'b0, 8'h20);
    ld(2'h1, 1'b0, 8'h00);
    wr(s, b);
    chk(lock_bits_o, 8'hfc);
    dly = 30;
    hv_entry_i = 0;
    tick(8);
    chk({eff_fuse_ext_o, eff_fuse_low_o, eff_fuse_high_o}, 24'hffffd7);
    chk({clock_div8_en_o, clock_out_en_o}, 2'h0);
    enter();
  endtask
  task t_read;
    logic [7:0] sg[3] = '{SIG0, SIG1, SIG2};
    ld(2'h2, 1'b0, 8'h08);
    for (int i = 0; i < 3; i++) begin
      ld(2'h0, 1'b0, i[7:0]);
      rd(1'b0, sg[i]);
    end
    ld(2'h0, 1'b0, 8'h00);
    rd(1'b1, CAL);
    ld(2'h2, 1'b0, 8'h02);
    ld(2'h0, 1'b1, 8'h12);
    ld(2'h0, 1'b0, 8'h34);
    chk({mem_addr_o, page_index_o}, {16'h1234, 7'h48});
    rd(1'b0, 8'h34 ^ MASK[7:0]);
    rd(1'b1, 8'h12 ^ MASK[15:8]);
    ld(2'h3, 1'b0, 8'h99);
    chk(mem_addr_o, 16'h1234);
    ld(2'h2, 1'b0, 8'h03);
    ld(2'h0, 1'b0, 8'h0d);
    chk(page_index_o, 7'h03);
    rd(1'b0, 8'h0d ^ MASK[7:0]);
    ld(2'h2, 1'b0, 8'h04);
    rd(1'b1, 8'hd7);
    rd(1'b0, 8'hff);
    ld(2'h1, 1'b0, 8'h00);
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hfc);
  endtask
  task t_unknown;
    ld(2'h2, 1'b0, 8'h55);
    output_enable_n_i = 0;
    tick(8);
    chk(data_oe_o, 0);
    output_enable_n_i = 1;
    tick(8);
    wr(s, b);
    chk(s, 0);
  endtask
  initial begin
    {nrst_i, prog_clock_pin_i, action_select_hi_i, action_select_lo_i} = 4'h0;
    {page_latch_strobe_i, hv_entry_i} = 2'h0;
    {write_n_i, output_enable_n_i} = 2'h3;
    data_i = 8'h00;
    dly = 30;
    tick(16);
    nrst_i = 1;
    tick(4);
    t_reset();
    enter();
    t_wflash();
    t_cmds();
    t_fuse();
    t_read();
    t_unknown();
    results();
  end
endmodule
